//--- core/mtp_regs.vh
// register offsets, field positions, reset values and timing figures for the mac timer period block
`ifndef MTP_REGS_VH
`define MTP_REGS_VH

`define MTP_ADDR_W        8
`define MTP_OFS_MATCH     8'h94
`define MTP_OFS_TALLY_LO  8'hA1
`define MTP_OFS_TALLY_MID 8'hA2
`define MTP_OFS_TALLY_HI  8'hA3
`define MTP_OFS_PER_LO    8'hA4
`define MTP_OFS_PER_HI    8'hA5
`define MTP_OFS_CTRL      8'hB0
`define MTP_OFS_STATUS    8'hB1
`define MTP_OFS_MASK      8'hB2

`define MTP_MATCH_RST     8'h00
`define MTP_TALLY_RST     20'h00000
`define MTP_PER_BYTE_RST  8'hFF

`define MTP_CTRL_RUN      0
`define MTP_CTRL_SEL      3
`define MTP_STAT_MATCH    0
`define MTP_STAT_WRAP     1

`define MTP_CLK_PERIOD_NS 8
`define MTP_TICK_NS       8
`define MTP_TICK_CYC      ((`MTP_TICK_NS + `MTP_CLK_PERIOD_NS - 1) / `MTP_CLK_PERIOD_NS)
// last count of the tick divider; zero while the timer advances every cycle
`define MTP_TICK_LAST     4'h0

`endif

//--- core/mtp_timer_core.v
// 16-bit timer with period wrap and byte compare
`timescale 1ns/10ps
`default_nettype none

module mtp_timer_core (
   // clock and reset
   input  wire        mclk,
   input  wire        rst_b,
   // control
   input  wire        runEn,
   input  wire        tickEn,
   input  wire        matchByteSelect,
   input  wire [7:0]  matchValue,
   input  wire [15:0] periodVal,
   // results
   output reg  [15:0] timerVal_r,
   output wire        wrapEvt,
   output wire        matchHit
);

   // wrap is taken when the current count has reached or passed the period
   assign wrapEvt = runEn && tickEn && (timerVal_r >= periodVal);
   // [RULE11] byte select: clear compares high byte, set compares low byte
   assign matchHit = runEn && tickEn &&
                     ((matchByteSelect ? timerVal_r[7:0] : timerVal_r[15:8]) == matchValue); // [RULE1]

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         timerVal_r <= 16'h0000;
      end else if (wrapEvt) begin
         timerVal_r <= 16'h0000; // [RULE13]
      end else if (runEn && tickEn) begin
         timerVal_r <= timerVal_r + 16'h0001;
      end
   end

endmodule

`default_nettype wire

//--- core/mtp_mac_timer.v
// mac timer register block: compare, wrap tally, period/capture, interrupt status
// Function
// RULE1: a compare event is raised when the selected timer byte equals the match value.
// RULE2: a 20-bit wrap tally over three byte registers increments each time the timer reaches the period.
// RULE3: reading the tally low byte snapshots the middle and high bytes for later reads.
// RULE4: low and middle tally writes are held pending and all 20 bits load when the high byte is written.
// RULE5: a software load of the tally is accepted whether the timer is idle or running.
// RULE6: a wrap in the same cycle as a tally load stores the written value plus one.
// RULE7: writing the period high register sets period bits 15:8 while reading it gives captured timer bits 15:8.
// RULE8: writing the period low register sets period bits 7:0 while reading it gives captured timer bits 7:0.
// RULE9: both period bytes reset to all ones.
// RULE10: the upper four bits of the tally high register read as zero and match value and tally reset to zero.
// RULE11: the byte select bit picks timer bits 15:8 when clear and bits 7:0 when set.
// RULE12: each compare event sets a sticky flag that only software clears and writing one leaves unchanged.
// RULE13: on reaching the period the timer returns to zero in the same cycle the tally increments.
`timescale 1ns/10ps
`default_nettype none
`include "mtp_regs.vh"

module mtp_mac_timer (
   // clock and reset
   input  wire                   mclk,
   input  wire                   rst_b,
   // register port
   input  wire [`MTP_ADDR_W-1:0] regAddr,
   input  wire [7:0]             regWdata,
   input  wire                   regWr,
   input  wire                   regRd,
   output reg  [7:0]             regRdata_r,
   // capture event from the surrounding timer, asynchronous
   input  wire                   captureIn,
   // interrupt and status
   output reg                    irq_r,
   output reg                    matchEvt_r,
   output reg                    wrapEvt_r
);

   // capture pin crosses in through two flip-flops
   reg        capSync1_r;
   reg        capSync2_r;
   reg        capSync3_r;
   wire       capEvt;

   reg [7:0]  matchValue_r;
   reg [19:0] wrapTally_r;
   reg [7:0]  tallyLoPend_r;
   reg [7:0]  tallyMidPend_r;
   reg [7:0]  snapMid_r;
   reg [3:0]  snapHigh_r;
   reg [15:0] period_r;
   reg [15:0] capture_r;
   reg [7:0]  ctrl_r;
   reg [7:0]  status_r;
   reg [7:0]  mask_r;
   reg [7:0]  status_nxt;
   reg [7:0]  rdata_nxt;
   reg [19:0] tally_nxt;
   reg [19:0] tallyLoad;
   reg [3:0]  tickCnt_r;
   reg        tickEn_r;

   wire [15:0] timerVal;
   wire        wrapEvt;
   wire        matchHit;

   // register access strobes for every register write and the two side-effect reads; the read mux decodes the address itself
   wire        wrMatch;
   wire        wrTallyLo;
   wire        wrTallyMid;
   wire        wrTallyHi;
   wire        wrPerLo;
   wire        wrPerHi;
   wire        wrCtrl;
   wire        wrStatus;
   wire        wrMask;
   wire        rdTallyLo;
   wire        rdStatus;

   // true when the address matches the given offset
   function hitAddr;
      input [`MTP_ADDR_W-1:0] a;
      input [`MTP_ADDR_W-1:0] ofs;
      begin
         hitAddr = (a == ofs);
      end
   endfunction

   // write strobes
   assign wrMatch    = regWr & hitAddr(regAddr, `MTP_OFS_MATCH);
   assign wrTallyLo  = regWr & hitAddr(regAddr, `MTP_OFS_TALLY_LO);
   assign wrTallyMid = regWr & hitAddr(regAddr, `MTP_OFS_TALLY_MID);
   assign wrTallyHi  = regWr & hitAddr(regAddr, `MTP_OFS_TALLY_HI);
   assign wrPerLo    = regWr & hitAddr(regAddr, `MTP_OFS_PER_LO);
   assign wrPerHi    = regWr & hitAddr(regAddr, `MTP_OFS_PER_HI);
   assign wrCtrl     = regWr & hitAddr(regAddr, `MTP_OFS_CTRL);
   assign wrStatus   = regWr & hitAddr(regAddr, `MTP_OFS_STATUS);
   assign wrMask     = regWr & hitAddr(regAddr, `MTP_OFS_MASK);

   // these two reads have side effects, so only the read strobe may trigger them
   assign rdTallyLo  = regRd & hitAddr(regAddr, `MTP_OFS_TALLY_LO);
   assign rdStatus   = regRd & hitAddr(regAddr, `MTP_OFS_STATUS);

   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         capSync1_r <= 1'b0;
         capSync2_r <= 1'b0;
         capSync3_r <= 1'b0;
      end else begin
         capSync1_r <= captureIn;
         capSync2_r <= capSync1_r;
         capSync3_r <= capSync2_r;
      end
   end

   assign capEvt = capSync2_r & ~capSync3_r;

   // timer advance rate; at one cycle the enable stays high
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tickCnt_r <= 4'h0;
         tickEn_r  <= 1'b0;
      end else if (tickCnt_r >= `MTP_TICK_LAST) begin
         tickCnt_r <= 4'h0;
         tickEn_r  <= 1'b1;
      end else begin
         tickCnt_r <= tickCnt_r + 4'h1;
         tickEn_r  <= 1'b0;
      end
   end

   mtp_timer_core uCore (
      .mclk            (mclk),
      .rst_b           (rst_b),
      .runEn           (ctrl_r[`MTP_CTRL_RUN]),
      .tickEn          (tickEn_r),
      .matchByteSelect (ctrl_r[`MTP_CTRL_SEL]),
      .matchValue      (matchValue_r),
      .periodVal       (period_r),
      .timerVal_r      (timerVal),
      .wrapEvt         (wrapEvt),
      .matchHit        (matchHit)
   );

   // tally next value: load wins over count, but a coincident wrap still adds one
   always @* begin
      tallyLoad = {regWdata[3:0], tallyMidPend_r, tallyLoPend_r};
      tally_nxt = wrapTally_r;
      // only the high byte write touches the live count
      if (wrTallyHi) begin
         if (wrapEvt) begin
            tally_nxt = tallyLoad + 20'h00001; // [RULE6]
         end else begin
            tally_nxt = tallyLoad; // [RULE4] [RULE5]
         end
      end else if (wrapEvt) begin
         tally_nxt = wrapTally_r + 20'h00001; // [RULE2]
      end
   end

   // status: hardware set wins over a read clear in the same cycle
   always @* begin
      status_nxt = status_r;
      if (rdStatus) begin
         status_nxt = 8'h00;
      end
      if (wrStatus) begin
         status_nxt = status_r & regWdata; // [RULE12]
      end
      if (matchHit) begin
         status_nxt[`MTP_STAT_MATCH] = 1'b1; // [RULE12]
      end
      if (wrapEvt) begin
         status_nxt[`MTP_STAT_WRAP] = 1'b1;
      end
   end

   // tally and status take their next values every cycle
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wrapTally_r <= `MTP_TALLY_RST; // [RULE10]
         status_r    <= 8'h00;
      end else begin
         wrapTally_r <= tally_nxt;
         status_r    <= status_nxt;
      end
   end

   // capture follows the synchronised pin edge, never the bus
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         capture_r <= 16'h0000;
      end else if (capEvt) begin
         capture_r <= timerVal;
      end
   end

   // the low byte read freezes the upper bits so a byte-wise read stays coherent
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         snapMid_r  <= 8'h00;
         snapHigh_r <= 4'h0;
      end else if (rdTallyLo) begin
         snapMid_r  <= wrapTally_r[15:8]; // [RULE3]
         snapHigh_r <= wrapTally_r[19:16]; // [RULE3]
      end
   end

   // low and middle writes wait here until the high byte arrives
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tallyLoPend_r  <= 8'h00;
         tallyMidPend_r <= 8'h00;
      end else begin
         if (wrTallyLo) begin
            tallyLoPend_r <= regWdata; // [RULE4]
         end
         if (wrTallyMid) begin
            tallyMidPend_r <= regWdata; // [RULE4]
         end
      end
   end

   // period is write-only; its addresses read back the capture value
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         period_r <= {`MTP_PER_BYTE_RST, `MTP_PER_BYTE_RST}; // [RULE9]
      end else begin
         if (wrPerLo) begin
            period_r[7:0] <= regWdata; // [RULE8]
         end
         if (wrPerHi) begin
            period_r[15:8] <= regWdata; // [RULE7]
         end
      end
   end

   // plain read/write registers; unused control and mask bits stay zero
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         matchValue_r <= `MTP_MATCH_RST; // [RULE10]
         ctrl_r       <= 8'h00;
         mask_r       <= 8'h00;
      end else begin
         if (wrMatch) begin
            matchValue_r <= regWdata;
         end
         if (wrCtrl) begin
            ctrl_r <= regWdata & 8'h09;
         end
         if (wrMask) begin
            mask_r <= regWdata & 8'h03;
         end
      end
   end

   // read mux; unmapped addresses read zero
   always @* begin
      rdata_nxt = 8'h00;
      if (hitAddr(regAddr, `MTP_OFS_MATCH)) begin
         rdata_nxt = matchValue_r;
      end else if (hitAddr(regAddr, `MTP_OFS_TALLY_LO)) begin
         rdata_nxt = wrapTally_r[7:0];
      end else if (hitAddr(regAddr, `MTP_OFS_TALLY_MID)) begin
         rdata_nxt = snapMid_r; // [RULE3]
      end else if (hitAddr(regAddr, `MTP_OFS_TALLY_HI)) begin
         rdata_nxt = {4'h0, snapHigh_r}; // [RULE10]
      end else if (hitAddr(regAddr, `MTP_OFS_PER_LO)) begin
         rdata_nxt = capture_r[7:0]; // [RULE8]
      end else if (hitAddr(regAddr, `MTP_OFS_PER_HI)) begin
         rdata_nxt = capture_r[15:8]; // [RULE7]
      end else if (hitAddr(regAddr, `MTP_OFS_CTRL)) begin
         rdata_nxt = ctrl_r;
      end else if (hitAddr(regAddr, `MTP_OFS_STATUS)) begin
         rdata_nxt = status_r;
      end else if (hitAddr(regAddr, `MTP_OFS_MASK)) begin
         rdata_nxt = mask_r;
      end
   end

   // read data stands for the one cycle after the strobe and is zero otherwise
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         regRdata_r <= 8'h00;
      end else begin
         regRdata_r <= regRd ? rdata_nxt : 8'h00;
      end
   end

   // irq follows the next status so a same-cycle set is never lost behind a clear
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_r      <= 1'b0;
         matchEvt_r <= 1'b0;
         wrapEvt_r  <= 1'b0;
      end else begin
         irq_r      <= |(status_nxt & mask_r);
         matchEvt_r <= matchHit; // [RULE1]
         wrapEvt_r  <= wrapEvt; // [RULE13]
      end
   end

endmodule

`default_nettype wire

//--- test/mtp_mac_timer_properties.sv
// port checker for the mac timer register block
`timescale 1ns/10ps
`default_nettype none
`include "mtp_regs.vh"
module mtp_mac_timer_chk (
   // clock and reset
   input wire logic       mclk,
   input wire logic       rst_b,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regRdata_r,
   // events
   input wire logic       captureIn,
   input wire logic       irq_r,
   input wire logic       matchEvt_r,
   input wire logic       wrapEvt_r
);
   logic [1:0] mask_r;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // mask mirror, so the irq checks know which events may raise the line
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b) mask_r <= 2'h0;
      else if (regWr && regAddr == `MTP_OFS_MASK) mask_r <= regWdata[1:0];
   property p_idle; !regRd |=> regRdata_r == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("data without read");
   property p_hi; regRd && regAddr == `MTP_OFS_TALLY_HI |=> regRdata_r[7:4] == 4'h0;
   endproperty
   a_hi: assert property (p_hi) else $error("tally top bits set");
   property p_cmp; regWr && regAddr == `MTP_OFS_MATCH ##1 !regWr
      ##1 regRd && regAddr == `MTP_OFS_MATCH |=> regRdata_r == $past(regWdata, 3); endproperty
   a_cmp: assert property (p_cmp) else $error("match value lost");
   // a wrap may land on the load and on the idle cycles after it
   property p_load; regWr && regAddr == `MTP_OFS_TALLY_LO ##1 !regWr
      ##1 regWr && regAddr == `MTP_OFS_TALLY_HI ##1 !regWr ##1 regRd && regAddr == `MTP_OFS_TALLY_LO
      |=> 8'(regRdata_r - $past(regWdata, 5)) <= 8'h03; endproperty
   a_load: assert property (p_load) else $error("tally load wrong");
   property p_snap; regRd && regAddr == `MTP_OFS_TALLY_MID ##1 !regWr && !regRd
      ##1 regRd && regAddr == `MTP_OFS_TALLY_MID |=> regRdata_r == $past(regRdata_r, 2);
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot moved");
   property p_mo; regWr && regAddr == `MTP_OFS_MASK && regWdata[1:0] == 2'h0 |-> ##[1:2] !irq_r;
   endproperty
   a_mo: assert property (p_mo) else $error("irq with mask off");
   property p_wi; wrapEvt_r && mask_r[1] |-> ##[0:2] irq_r; endproperty
   a_wi: assert property (p_wi) else $error("wrap irq missing");
   property p_mi; matchEvt_r && mask_r[0] |-> ##[0:2] irq_r; endproperty
   a_mi: assert property (p_mi) else $error("match irq missing");
endmodule
bind mtp_mac_timer mtp_mac_timer_chk u_chk (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r),
   .captureIn(captureIn), .irq_r(irq_r), .matchEvt_r(matchEvt_r), .wrapEvt_r(wrapEvt_r));
`default_nettype wire

//--- test/tb.sv
// random and corner-case bench for the mac timer register block
`timescale 1ns/10ps
`default_nettype none
`include "mtp_regs.vh"
module tb;
   logic        mclk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, captureIn = 1'b0;
   logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, g, c0, c1, wrapCnt = 8'h00;
   logic [15:0] per, t;
   logic [19:0] v;
   wire  [7:0]  regRdata_r;
   wire         irq_r, matchEvt_r, wrapEvt_r;
   int          n_mismatch = 0, samples_checked = 0, k, last;
   mtp_mac_timer u_mtp_mac_timer (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r),
      .captureIn(captureIn), .irq_r(irq_r), .matchEvt_r(matchEvt_r), .wrapEvt_r(wrapEvt_r));
   always #4 mclk = ~mclk;
   always @(posedge mclk) if (wrapEvt_r === 1'b1) wrapCnt <= wrapCnt + 8'h01;
   function automatic logic [7:0] wrapGap(input logic [15:0] p);
      return 8'(p + 16'h0001);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= x;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      g = regRdata_r;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      chk(g, exp);
   endtask
   task automatic waitm(input logic [7:0] exp);
      c0 = 8'h00;
      repeat (40) begin
         @(posedge mclk);
         #1;
         if (matchEvt_r === 1'b1) c0 = 8'h01;
      end
      chk(c0, exp);
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #400000;
      n_mismatch++;
      test_done;
   end
   initial begin
      void'($urandom(57));
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      rdc(`MTP_OFS_MATCH, 8'h00);
      rdc(`MTP_OFS_TALLY_HI, 8'h00);
      // about 300 ticks on the reset period must not wrap
      wr(`MTP_OFS_CTRL, 8'h01);
      repeat (300) @(posedge mclk);
      wr(`MTP_OFS_CTRL, 8'h00);
      chk(wrapCnt, 8'h00);
      captureIn <= 1'b1;
      repeat (4) @(posedge mclk);
      captureIn <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(`MTP_OFS_PER_LO);
      c1 = g;
      rd(`MTP_OFS_PER_HI);
      t = {g, c1};
      chk({7'h00, t > 16'h0126 && t < 16'h0138}, 8'h01);
      wr(`MTP_OFS_PER_LO, ~c1);
      rdc(`MTP_OFS_PER_LO, c1);
      for (k = 0; k < 8; k++) begin
         c0 = 8'($urandom);
         wr(`MTP_OFS_MATCH, c0);
         rdc(`MTP_OFS_MATCH, c0);
      end
      v = 20'($urandom);
      c0 = 8'($urandom);
      wr(`MTP_OFS_TALLY_MID, v[15:8]);
      rdc(`MTP_OFS_TALLY_LO, 8'h00);
      wr(`MTP_OFS_TALLY_LO, v[7:0]);
      wr(`MTP_OFS_TALLY_HI, {c0[7:4], v[19:16]});
      rdc(`MTP_OFS_TALLY_LO, v[7:0]);
      rdc(`MTP_OFS_TALLY_MID, v[15:8]);
      rdc(`MTP_OFS_TALLY_MID, v[15:8]);
      rdc(`MTP_OFS_TALLY_HI, {4'h0, v[19:16]});
      wr(`MTP_OFS_TALLY_MID, 8'h00);
      wr(`MTP_OFS_TALLY_LO, 8'h00);
      wr(`MTP_OFS_TALLY_HI, 8'h00);
      per = {12'h000, c0[3:0]} + 16'h0003;
      wr(`MTP_OFS_PER_LO, per[7:0]);
      wr(`MTP_OFS_PER_HI, 8'h00);
      wr(`MTP_OFS_MATCH, 8'h01);
      wr(`MTP_OFS_MASK, 8'h02);
      wr(`MTP_OFS_CTRL, 8'h01);
      last = 0;
      for (k = 1; k < 120; k++) begin
         @(posedge mclk);
         #1;
         if (wrapEvt_r === 1'b1) begin
            if (last > 0) chk(8'(k - last), wrapGap(per));
            last = k;
         end
      end
      chk({7'h00, irq_r}, 8'h01);
      wr(`MTP_OFS_CTRL, 8'h00);
      repeat (2) @(posedge mclk);
      rdc(`MTP_OFS_TALLY_LO, wrapCnt);
      rd(`MTP_OFS_STATUS);
      chk(g & 8'h02, 8'h02);
      @(posedge mclk);
      #1;
      chk({7'h00, irq_r}, 8'h00);
      wr(`MTP_OFS_MASK, 8'h01);
      wr(`MTP_OFS_CTRL, 8'h09);
      waitm(8'h01);
      wr(`MTP_OFS_CTRL, 8'h00);
      rd(`MTP_OFS_STATUS);
      chk(g & 8'h01, 8'h01);
      rd(`MTP_OFS_STATUS);
      chk(g & 8'h01, 8'h00);
      wr(`MTP_OFS_CTRL, 8'h01);
      waitm(8'h00);
      wr(`MTP_OFS_MASK, 8'h00);
      // load the tally while running, on the very edge of a wrap
      wr(`MTP_OFS_TALLY_LO, v[7:0]);
      wr(`MTP_OFS_TALLY_MID, v[15:8]);
      k = 0;
      while (k == 0) begin
         @(posedge mclk);
         #1;
         if (wrapEvt_r === 1'b1) k = 1;
      end
      repeat (per - 16'h0001) @(posedge mclk);
      wr(`MTP_OFS_TALLY_HI, {c0[7:4], v[19:16]});
      wr(`MTP_OFS_CTRL, 8'h00);
      v = v + 20'h00001;
      rdc(`MTP_OFS_TALLY_LO, v[7:0]);
      rdc(`MTP_OFS_TALLY_MID, v[15:8]);
      rdc(`MTP_OFS_TALLY_HI, {4'h0, v[19:16]});
      test_done;
   end
endmodule
`default_nettype wire
